// ==== pkg/lpddr_pkg.sv ====
// constants, pin groups and state types for the low-power ddr command and bank logic
// assumes an x16 data path, four banks and a small flip-flop array behind them
package lpddr_pkg;

   // data path: one core word is two pin beats
   localparam int DQ_W = 16;
   localparam int BYTES = 2;
   localparam int WORD_W = 32;
   localparam int MASK_W = 4;

   // address and array geometry
   localparam int BANKS = 4;
   localparam int ADDR_W = 13;
   localparam int ROW_IDX_W = 2;
   localparam int WORD_IDX_W = 3;
   localparam int MEM_WORDS = 128;
   localparam int MEM_IDX_W = 7;
   localparam int COL_LSB = 1;
   localparam int AP_BIT = 10;

   // load mode targets selected by the bank bits
   localparam logic [1:0] MR_SEL_STD = 2'h0;
   localparam logic [1:0] MR_SEL_EXT = 2'h1;
   localparam logic [1:0] MR_SEL_STATUS = 2'h2;

   // burst length and order fields of the standard mode register
   localparam int BL_LSB = 0;
   localparam int BL_W = 3;
   localparam int ORDER_BIT = 3;
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   localparam logic [2:0] BL_CODE_16 = 3'h4;
   localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;

   // row-precharge time on the link clock, rounded up
   localparam int T_RP_NS = 20;
   localparam int LINK_PERIOD_NS = 12;
   localparam int T_RP_CYC = (T_RP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam int RP_CNT_W = 4;
   localparam logic [RP_CNT_W-1:0] RP_LOAD = 4'(T_RP_CYC - 1);

   // self refresh row interval on the core clock, rounded down
   localparam int SR_INTERVAL_PS = 7812500;
   localparam int CORE_PERIOD_PS = 50000;
   localparam int SR_INT_CYC = SR_INTERVAL_PS / CORE_PERIOD_PS;
   localparam int SR_CNT_W = 8;
   localparam logic [SR_CNT_W-1:0] SR_INT_LAST = 8'(SR_INT_CYC - 1);

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [1:0] ba;
      logic [ADDR_W-1:0] addr;
   } cmd_pins_t;

   typedef struct packed {
      logic self_refresh;
      logic deep_pd;
      logic [BANKS-1:0] bank_open;
      logic [ROW_IDX_W-1:0] refresh_row;
   } status_t;

   typedef enum logic [3:0] {
      CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_REF, CMD_MRS
   } cmd_t;
   typedef enum logic [1:0] {PW_ACTIVE, PW_DOWN, PW_SELF_REF, PW_DEEP_PD} pwr_t;
   typedef enum logic [1:0] {BK_IDLE, BK_OPEN, BK_PRECH} bank_st_t;
   typedef enum logic [1:0] {BS_NONE, BS_READ, BS_WRITE} bst_t;

endpackage

// ==== tb/lpddr_command_bank_logic_tb.sv ====
// testbench: controller model drives the link, bench judges read data and status
// assumes status settles within ten core cycles of the link event behind it
`timescale 1ns/100ps
module lpddr_command_bank_logic_tb;
   import lpddr_pkg::*;
   localparam logic [3:0] C_MRS = 4'h0;
   localparam logic [3:0] C_REF = 4'h1;
   localparam logic [3:0] C_PRE = 4'h2;
   localparam logic [3:0] C_ACT = 4'h3;
   localparam logic [3:0] C_WR = 4'h4;
   localparam logic [3:0] C_RD = 4'h5;
   localparam logic [3:0] C_BST = 4'h6;
   logic clock_in;
   logic reset_n_in;
   logic ck;
   logic cke;
   cmd_pins_t cmd;
   logic [DQ_W-1:0] m_dq;
   logic [DQ_W-1:0] dq_out;
   logic [DQ_W-1:0] dq_w;
   logic [BYTES-1:0] m_dqs;
   logic [BYTES-1:0] dqs_out;
   logic [BYTES-1:0] dqs_w;
   logic [BYTES-1:0] dm;
   logic dq_oe_out;
   logic dqs_oe_out;
   status_t st;
   int errors;
   int n_checks;

   // wire level from both parties
   assign dq_w = dq_oe_out ? dq_out : m_dq;
   assign dqs_w = dqs_oe_out ? dqs_out : m_dqs;

   lpddr_command_bank_logic lpddr_command_bank_logic_i (
      .clock_in(clock_in), .reset_n_in(reset_n_in), .ck_in(ck), .cke_in(cke),
      .cmd_in(cmd), .dq_in(dq_w), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
      .dqs_in(dqs_w), .dqs_out(dqs_out), .dqs_oe_out(dqs_oe_out), .dm_in(dm),
      .status_out(st));

   lpddr_ctrl_model lpddr_ctrl_model_i (
      .ck_out(ck), .cke_out(cke), .cmd_out(cmd), .dq_out(m_dq), .dqs_out(m_dqs),
      .dm_out(dm));

   initial
   begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic bad(input string s);
      errors++;
      $display("MISMATCH %0t %s", $time, s);
   endtask

   task automatic cmp_w(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e)
         bad($sformatf("data %h exp %h", g, e));
   endtask

   task automatic cmp_b(input logic g, input logic e);
      n_checks++;
      if (g !== e)
         bad($sformatf("flag %b exp %b", g, e));
   endtask

   // status is synchronised, so poll it for a bounded span
   task automatic st_chk(input logic [7:0] e, input logic [7:0] m);
      int i;
      for (i = 0; i < 10 && (st & m) !== e; i++)
         @(posedge clock_in);
      n_checks++;
      if ((st & m) !== e)
         bad($sformatf("status %h exp %h", st, e));
   endtask

   task automatic send(input logic [3:0] c, input logic [1:0] ba, input logic [12:0] a);
      lpddr_ctrl_model_i.issue(c, ba, a, 1'b1);
   endtask

   // read words land one link cycle after the command, low beat while ck is high
   task automatic rd_chk(input logic [1:0] ba, input logic [12:0] a, input logic [63:0] e,
      input int nw);
      int k;
      send(C_RD, ba, a);
      for (k = 0; k < nw; k++)
      begin
         @(posedge ck);
         #3 cmp_b(dq_oe_out & dqs_oe_out, 1'b1);
         cmp_b(&dqs_out, 1'b1);
         cmp_w(dq_out, e[32*k +: 16]);
         #6 cmp_w(dq_out, e[32*k+16 +: 16]);
         cmp_b(|dqs_out, 1'b0);
      end
      @(posedge ck);
      #3 cmp_b(dq_oe_out, 1'b0);
   endtask

   task automatic t_wr_rd();
      send(C_ACT, 2'h1, 13'h0002);
      st_chk(8'h08, 8'h3c);
      send(C_WR, 2'h1, 13'h0004);
      lpddr_ctrl_model_i.wdat(32'habcd1234, 4'h0);
      send(C_WR, 2'h1, 13'h0006);
      lpddr_ctrl_model_i.wdat(32'hf0f00f0f, 4'h0);
      send(C_WR, 2'h1, 13'h0004);
      lpddr_ctrl_model_i.wdat(32'hef015678, 4'h6);
      rd_chk(2'h1, 13'h0004, {32'h0, 32'hefcd1278}, 1);
      st_chk(8'h08, 8'h3c);
   endtask

   task automatic t_burst();
      send(C_PRE, 2'h2, 13'h0400);
      st_chk(8'h00, 8'h3c);
      // load mode only with all banks idle
      send(C_MRS, MR_SEL_STD, 13'h0002);
      send(C_ACT, 2'h1, 13'h0002);
      rd_chk(2'h1, 13'h0406, {32'hefcd1278, 32'hf0f00f0f}, 2);
      st_chk(8'h00, 8'h3c);
   endtask

   // interleaved length-eight read from column one, cut after two words
   task automatic t_term();
      send(C_MRS, MR_SEL_STD, 13'h000b);
      send(C_ACT, 2'h1, 13'h0002);
      send(C_RD, 2'h1, 13'h0002);
      fork
         send(C_BST, 2'h0, 13'h0000);
         begin
            @(posedge ck);
            #3 cmp_b(dq_oe_out, 1'b1);
            cmp_w(dq_out, 16'h0000);
            #6 cmp_w(dq_out, 16'h0000);
            @(posedge ck);
            #3 cmp_w(dq_out, 16'h0000);
            #6 cmp_w(dq_out, 16'h0000);
            @(posedge ck);
            #3 cmp_b(dq_oe_out, 1'b0);
         end
      join
      st_chk(8'h08, 8'h3c);
      send(C_PRE, 2'h1, 13'h0000);
      st_chk(8'h00, 8'h3c);
   endtask

   task automatic t_power();
      // one refresh, well inside the refresh period
      send(C_REF, 2'h3, 13'h1fff);
      st_chk(8'h01, 8'hff);
      lpddr_ctrl_model_i.issue(C_REF, 2'h0, 13'h0000, 1'b0);
      st_chk(8'h80, 8'h80);
      lpddr_ctrl_model_i.wake();
      st_chk(8'h00, 8'h80);
      lpddr_ctrl_model_i.issue(C_BST, 2'h0, 13'h0000, 1'b0);
      st_chk(8'h40, 8'h40);
      lpddr_ctrl_model_i.wake();
      st_chk(8'h00, 8'h40);
      send(C_ACT, 2'h1, 13'h0002);
      rd_chk(2'h1, 13'h0004, 64'h0, 1);
   endtask

   // watchdog: whole run takes a few microseconds
   initial
   begin
      #100000;
      bad("watchdog");
      end_sim();
   end

   initial
   begin
      errors = 0;
      n_checks = 0;
      reset_n_in = 1'b0;
      repeat (5) @(posedge clock_in);
      reset_n_in <= 1'b1;
      repeat (4) @(posedge ck);
      t_wr_rd();
      t_burst();
      t_term();
      t_power();
      end_sim();
   end
endmodule

// ==== tb/lpddr_ctrl_model.sv ====
// memory controller model: link clock, commands, write strobe, data and masks
// assumes the bench calls one task at a time and muxes dq and dqs by the device enables
`timescale 1ns/100ps
module lpddr_ctrl_model (
   // link clock and commands
   output logic ck_out,
   output logic cke_out,
   output lpddr_pkg::cmd_pins_t cmd_out,
   // write data
   output logic [lpddr_pkg::DQ_W-1:0] dq_out,
   output logic [lpddr_pkg::BYTES-1:0] dqs_out,
   output logic [lpddr_pkg::BYTES-1:0] dm_out
);
   import lpddr_pkg::*;

   initial
   begin
      ck_out = 1'b0;
      cke_out = 1'b1;
      cmd_out = cmd_pins_t'({4'h7, 15'h0});
      dq_out = 16'h0;
      dqs_out = 2'h0;
      dm_out = 2'h0;
      #3.7;
      forever #6 ck_out = ~ck_out;
   end

   task automatic issue(input logic [3:0] code, input logic [1:0] ba, input logic [12:0] a,
      input logic ke);
      @(posedge ck_out);
      cmd_out <= cmd_pins_t'({code, ba, a});
      cke_out <= ke;
      @(posedge ck_out);
      // released fields show the inverse, never the old value
      cmd_out <= cmd_pins_t'({4'h7, ~ba, ~a});
   endtask

   task automatic wake();
      @(posedge ck_out);
      cke_out <= 1'b1;
      @(posedge ck_out);
   endtask

   task automatic wdat(input logic [31:0] w, input logic [3:0] m);
      @(posedge ck_out);
      dq_out <= w[15:0];
      dm_out <= m[1:0];
      #3 dqs_out <= 2'h3;
      #3 dq_out <= w[31:16];
      dm_out <= m[3:2];
      #3 dqs_out <= 2'h0;
      @(posedge ck_out);
      dq_out <= ~dq_out;
      dm_out <= ~dm_out;
   endtask
endmodule

// ==== verilog/lpddr_command_bank_logic.sv ====
// command decode, bank states, bursts and a small array of a low-power ddr sdram
// assumes the controller drives pins synchronous to ck_in and strobes centred in write data
`timescale 1ns/100ps

module lpddr_command_bank_logic (
   // core clock and reset
   input wire logic clock_in,
   input wire logic reset_n_in,
   // link clock and command pins
   input wire logic ck_in,
   input wire logic cke_in,
   input wire lpddr_pkg::cmd_pins_t cmd_in,
   // data pins
   input wire logic [lpddr_pkg::DQ_W-1:0] dq_in,
   output logic [lpddr_pkg::DQ_W-1:0] dq_out,
   output logic dq_oe_out,
   input wire logic [lpddr_pkg::BYTES-1:0] dqs_in,
   output logic [lpddr_pkg::BYTES-1:0] dqs_out,
   output logic dqs_oe_out,
   input wire logic [lpddr_pkg::BYTES-1:0] dm_in,
   // status in the core domain
   output lpddr_pkg::status_t status_out
);
   import lpddr_pkg::*;

   typedef struct packed {
      pwr_t pw;
      bank_st_t [BANKS-1:0] bank_st;
      logic [BANKS-1:0][ROW_IDX_W-1:0] open_row;
      logic [BANKS-1:0][RP_CNT_W-1:0] rp_cnt;
      bst_t bst;
      logic [1:0] bst_bank;
      logic [WORD_IDX_W-1:0] bst_start;
      logic [WORD_IDX_W-1:0] bst_idx;
      logic [WORD_IDX_W-1:0] bst_last;
      logic bst_ap;
      logic bst_ilv;
      logic wr_wait;
      logic [ADDR_W-1:0] mode_reg;
      logic [ADDR_W-1:0] emode_reg;
      logic [ADDR_W-1:0] stat_reg;
      logic [WORD_W-1:0] rd_word;
      logic rd_valid;
      logic ref_tgl;
      logic sr_flag;
      logic dpd_flag;
      logic [BANKS-1:0] open_flag;
      logic [MEM_WORDS-1:0][WORD_W-1:0] mem;
   } link_st_t;

   typedef struct packed {
      logic [1:0] sr_sync;
      logic [1:0] dpd_sync;
      logic [1:0][BANKS-1:0] open_sync;
      logic [2:0] ref_sync;
      logic [ROW_IDX_W-1:0] ref_row;
      logic [SR_CNT_W-1:0] sr_cnt;
   } core_st_t;

   link_st_t ls_r;
   link_st_t ls_nxt;
   core_st_t cs_r;
   core_st_t cs_nxt;
   logic [1:0] lrst_sync_r;
   logic [1:0] crst_sync_r;
   logic lrst_n;
   logic crst_n;
   wire [WORD_W-1:0] cap_word;
   wire [MASK_W-1:0] cap_mask;
   cmd_t cmd;
   logic live;
   logic banks_idle;
   logic all_idle;
   logic act_go;
   logic rd_go;
   logic wr_go;
   logic pre_go;
   logic bst_go;
   logic mrs_go;
   logic ref_go;
   logic sr_go;
   logic dpd_go;
   logic any_go;
   logic [WORD_IDX_W-1:0] mode_last;
   logic [MEM_IDX_W-1:0] widx;

   function automatic cmd_t decode_cmd(input cmd_pins_t p);
      cmd_t c;
      c = CMD_NOP;
      if (p.cs_n)
         c = CMD_DESEL;
      else
         case ({p.ras_n, p.cas_n, p.we_n})
            3'h7: c = CMD_NOP;
            3'h3: c = CMD_ACT;
            3'h5: c = CMD_RD;
            3'h4: c = CMD_WR;
            3'h6: c = CMD_BST;
            3'h2: c = CMD_PRE;
            3'h1: c = CMD_REF;
            3'h0: c = CMD_MRS;
            default: c = CMD_NOP;
         endcase
      return c;
   endfunction

   // burst length in core words, less one
   function automatic logic [WORD_IDX_W-1:0] burst_last(input logic [ADDR_W-1:0] m);
      logic [WORD_IDX_W-1:0] l;
      case (m[BL_LSB +: BL_W])
         BL_CODE_4: l = 3'h1;
         BL_CODE_8: l = 3'h3;
         BL_CODE_16: l = 3'h7;
         default: l = 3'h0;
      endcase
      return l;
   endfunction

   // reset release, one synchroniser per domain
   always_ff @(posedge ck_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         lrst_sync_r <= 2'h0;
      else
         lrst_sync_r <= {lrst_sync_r[0], 1'b1};
   end
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         crst_sync_r <= 2'h0;
      else
         crst_sync_r <= {crst_sync_r[0], 1'b1};
   end
   assign lrst_n = lrst_sync_r[1];
   assign crst_n = crst_sync_r[1];

   // per-byte strobe capture, rising beat low half, falling beat high half
   for (genvar ln = 0; ln < BYTES; ln++)
   begin : g_lane
      logic [7:0] rise_d_r;
      logic [7:0] fall_d_r;
      logic rise_m_r;
      logic fall_m_r;
      always_ff @(posedge dqs_in[ln])
      begin
         rise_d_r <= dq_in[ln*8 +: 8];
         rise_m_r <= dm_in[ln];
      end
      always_ff @(negedge dqs_in[ln])
      begin
         fall_d_r <= dq_in[ln*8 +: 8];
         fall_m_r <= dm_in[ln];
      end
      assign cap_word[ln*8 +: 8] = rise_d_r;
      assign cap_word[DQ_W + ln*8 +: 8] = fall_d_r;
      assign cap_mask[ln] = rise_m_r;
      assign cap_mask[BYTES + ln] = fall_m_r;
   end

   // command qualification
   always_comb
   begin
      cmd = decode_cmd(cmd_in);
      live = (ls_r.pw == PW_ACTIVE) && cke_in;
      banks_idle = 1'b1;
      for (int b = 0; b < BANKS; b++)
         if (ls_r.bank_st[b] != BK_IDLE)
            banks_idle = 1'b0;
      all_idle = banks_idle && (ls_r.bst == BS_NONE);
      mode_last = burst_last(ls_r.mode_reg);
      act_go = live && (cmd == CMD_ACT) && (ls_r.bank_st[cmd_in.ba] == BK_IDLE);
      rd_go = live && (cmd == CMD_RD) && (ls_r.bank_st[cmd_in.ba] == BK_OPEN);
      wr_go = live && (cmd == CMD_WR) && (ls_r.bank_st[cmd_in.ba] == BK_OPEN);
      pre_go = live && (cmd == CMD_PRE);
      bst_go = live && (cmd == CMD_BST) && (ls_r.bst == BS_READ) && !ls_r.bst_ap;
      mrs_go = live && (cmd == CMD_MRS) && all_idle;
      ref_go = live && (cmd == CMD_REF) && all_idle;
      sr_go = (ls_r.pw == PW_ACTIVE) && !cke_in && (cmd == CMD_REF) && all_idle;
      dpd_go = (ls_r.pw == PW_ACTIVE) && !cke_in && (cmd == CMD_BST);
      any_go = act_go | rd_go | wr_go | pre_go | bst_go | mrs_go | ref_go | sr_go | dpd_go;
   end

   // sequential wraps inside the burst block, interleaved flips low bits
   always_comb
   begin
      logic [WORD_IDX_W-1:0] lo;
      logic [WORD_IDX_W-1:0] col;
      lo = ls_r.bst_ilv ? (ls_r.bst_start ^ ls_r.bst_idx)
                        : WORD_IDX_W'(ls_r.bst_start + ls_r.bst_idx);
      col = (ls_r.bst_start & ~ls_r.bst_last) | (lo & ls_r.bst_last);
      widx = {ls_r.bst_bank, ls_r.open_row[ls_r.bst_bank], col};
   end

   // link-side next state
   always_comb
   begin
      ls_nxt = ls_r;
      ls_nxt.rd_valid = 1'b0;
      for (int b = 0; b < BANKS; b++)
         if (ls_r.bank_st[b] == BK_PRECH)
         begin
            if (ls_r.rp_cnt[b] <= 4'h1)
            begin
               ls_nxt.bank_st[b] = BK_IDLE;
               ls_nxt.rp_cnt[b] = 4'h0;
            end
            else
               ls_nxt.rp_cnt[b] = ls_r.rp_cnt[b] - 4'h1;
         end
      // one core word per cycle of an active burst
      if ((ls_r.bst == BS_READ) || ((ls_r.bst == BS_WRITE) && !ls_r.wr_wait))
      begin
         if (ls_r.bst == BS_READ)
         begin
            ls_nxt.rd_word = ls_r.mem[widx];
            ls_nxt.rd_valid = 1'b1;
         end
         else
            // masked bytes keep their old value
            for (int b = 0; b < MASK_W; b++)
               if (!cap_mask[b])
                  ls_nxt.mem[widx][b*8 +: 8] = cap_word[b*8 +: 8];
         if (ls_r.bst_idx == ls_r.bst_last)
         begin
            ls_nxt.bst = BS_NONE;
            if (ls_r.bst_ap)
            begin
               ls_nxt.bank_st[ls_r.bst_bank] = BK_PRECH;
               ls_nxt.rp_cnt[ls_r.bst_bank] = RP_LOAD;
            end
         end
         else
            ls_nxt.bst_idx = ls_r.bst_idx + 3'h1;
      end
      else if (ls_r.bst == BS_WRITE)
         ls_nxt.wr_wait = 1'b0;
      if (act_go)
      begin
         ls_nxt.bank_st[cmd_in.ba] = BK_OPEN;
         ls_nxt.open_row[cmd_in.ba] = cmd_in.addr[ROW_IDX_W-1:0];
      end
      // a new burst replaces any running one
      if (rd_go || wr_go)
      begin
         ls_nxt.bst = rd_go ? BS_READ : BS_WRITE;
         ls_nxt.bst_bank = cmd_in.ba;
         ls_nxt.bst_start = cmd_in.addr[COL_LSB +: WORD_IDX_W];
         ls_nxt.bst_idx = 3'h0;
         ls_nxt.bst_last = mode_last;
         ls_nxt.bst_ap = cmd_in.addr[AP_BIT];
         ls_nxt.bst_ilv = ls_r.mode_reg[ORDER_BIT];
         ls_nxt.wr_wait = wr_go;
      end
      if (pre_go)
      begin
         for (int b = 0; b < BANKS; b++)
            if (cmd_in.addr[AP_BIT] || (cmd_in.ba == 2'(b)))
            begin
               ls_nxt.bank_st[b] = BK_PRECH;
               ls_nxt.rp_cnt[b] = RP_LOAD;
            end
         if (cmd_in.addr[AP_BIT] || (cmd_in.ba == ls_r.bst_bank))
            ls_nxt.bst = BS_NONE;
      end
      // row of the cut read stays open
      if (bst_go)
         ls_nxt.bst = BS_NONE;
      if (mrs_go)
         case (cmd_in.ba)
            MR_SEL_STD: ls_nxt.mode_reg = cmd_in.addr;
            MR_SEL_EXT: ls_nxt.emode_reg = cmd_in.addr;
            MR_SEL_STATUS: ls_nxt.stat_reg = cmd_in.addr;
            default: ls_nxt.stat_reg = ls_r.stat_reg;
         endcase
      // refresh row comes from the core-side counter
      if (ref_go)
         ls_nxt.ref_tgl = !ls_r.ref_tgl;
      // clock enable low selects the power state
      if ((ls_r.pw == PW_ACTIVE) && !cke_in)
      begin
         if (sr_go)
            ls_nxt.pw = PW_SELF_REF;
         else if (dpd_go)
         begin
            ls_nxt.pw = PW_DEEP_PD;
            ls_nxt.mem = '0;
            ls_nxt.bank_st = '0;
            ls_nxt.bst = BS_NONE;
         end
         else
            ls_nxt.pw = PW_DOWN;
      end
      else if ((ls_r.pw != PW_ACTIVE) && cke_in)
      begin
         // leaving deep power-down needs a fresh set of mode registers
         if (ls_r.pw == PW_DEEP_PD)
         begin
            ls_nxt.mode_reg = MODE_RST;
            ls_nxt.emode_reg = MODE_RST;
            ls_nxt.stat_reg = MODE_RST;
         end
         ls_nxt.pw = PW_ACTIVE;
      end
      // flags leave the link domain straight from flops, never from decode
      ls_nxt.sr_flag = (ls_nxt.pw == PW_SELF_REF);
      ls_nxt.dpd_flag = (ls_nxt.pw == PW_DEEP_PD);
      for (int b = 0; b < BANKS; b++)
         ls_nxt.open_flag[b] = (ls_nxt.bank_st[b] == BK_OPEN);
   end

   // commands and link state are taken on the rising link clock, write data on the strobe edges
   always_ff @(posedge ck_in or negedge lrst_n)
   begin
      if (!lrst_n)
         ls_r <= '0;
      else
         ls_r <= ls_nxt;
   end

   // core side: level synchronisers and the internal refresh row counter
   always_comb
   begin
      cs_nxt = cs_r;
      cs_nxt.sr_sync = {cs_r.sr_sync[0], ls_r.sr_flag};
      cs_nxt.dpd_sync = {cs_r.dpd_sync[0], ls_r.dpd_flag};
      cs_nxt.open_sync = {cs_r.open_sync[0], ls_r.open_flag};
      cs_nxt.ref_sync = {cs_r.ref_sync[1:0], ls_r.ref_tgl};
      // the link clock may stop in self refresh, so rows advance on the core clock
      if (cs_r.sr_sync[1])
      begin
         if (cs_r.sr_cnt == SR_INT_LAST)
         begin
            cs_nxt.sr_cnt = 8'h00;
            cs_nxt.ref_row = cs_r.ref_row + 2'h1;
         end
         else
            cs_nxt.sr_cnt = cs_r.sr_cnt + 8'h01;
      end
      else
      begin
         cs_nxt.sr_cnt = 8'h00;
         if (cs_r.ref_sync[2] ^ cs_r.ref_sync[1])
            cs_nxt.ref_row = cs_r.ref_row + 2'h1;
      end
   end

   always_ff @(posedge clock_in or negedge crst_n)
   begin
      if (!crst_n)
         cs_r <= '0;
      else
         cs_r <= cs_nxt;
   end

   assign status_out.self_refresh = cs_r.sr_sync[1];
   assign status_out.deep_pd = cs_r.dpd_sync[1];
   assign status_out.bank_open = cs_r.open_sync[1];
   assign status_out.refresh_row = cs_r.ref_row;

   // read beats and strobe follow both link clock edges
   assign dq_out = ck_in ? ls_r.rd_word[DQ_W-1:0] : ls_r.rd_word[WORD_W-1:DQ_W];
   assign dq_oe_out = ls_r.rd_valid;
   assign dqs_out = {BYTES{ck_in}};
   assign dqs_oe_out = ls_r.rd_valid;

   localparam int RP_DLY = T_RP_CYC;
   localparam int RP_REST = T_RP_CYC - 1;

   default clocking @(posedge ck_in);
   endclocking
   default disable iff (!lrst_n);

   AST_ACT_OPENS: assert property (act_go |=> (ls_r.bank_st[$past(cmd_in.ba)] == BK_OPEN)
         && (ls_r.open_row[$past(cmd_in.ba)] == $past(cmd_in.addr[ROW_IDX_W-1:0])))
      else $error("activate did not open the row");
   AST_RD_LATENCY: assert property (rd_go |-> ##2 (dq_oe_out && dqs_oe_out))
      else $error("read data not driven one cycle after the command");
   AST_BURST_LEN4: assert property ((rd_go && (mode_last == 3'h1)) ##1 (!any_go) [*2]
         |-> dq_oe_out ##1 dq_oe_out ##1 !dq_oe_out)
      else $error("length-four read burst has wrong length");
   AST_AUTO_PRE: assert property ((rd_go && cmd_in.addr[AP_BIT] && (mode_last == 3'h0))
         |-> ##2 (ls_r.bank_st[$past(cmd_in.ba, 2)] == BK_PRECH))
      else $error("auto precharge did not start after the burst");
   AST_PRE_ONE: assert property ((pre_go && !cmd_in.addr[AP_BIT])
         |=> (ls_r.bank_st[$past(cmd_in.ba)] == BK_PRECH))
      else $error("single-bank precharge missed its bank");
   AST_PRE_ALL_TRP: assert property ((pre_go && cmd_in.addr[AP_BIT])
         |=> !banks_idle ##RP_REST banks_idle)
      else $error("banks not idle exactly one precharge time later");
   AST_BST_CUT: assert property (bst_go |=> (ls_r.bst == BS_NONE)
         && (ls_r.bank_st[$past(ls_r.bst_bank)] == BK_OPEN))
      else $error("terminate did not cut the read or closed the row");
   AST_SR_ENTRY: assert property (sr_go |=> (ls_r.pw == PW_SELF_REF))
      else $error("self refresh not entered");
   AST_DPD_LOSS: assert property (dpd_go |=> (ls_r.pw == PW_DEEP_PD) && (ls_r.mem == '0))
      else $error("deep power-down kept array contents");
   AST_NOP_STILL: assert property ((live && ((cmd == CMD_NOP) || (cmd == CMD_DESEL)))
         |=> $stable(ls_r.open_row) && $stable(ls_r.mode_reg))
      else $error("no-operation disturbed the state");
   AST_MODE_LOAD: assert property ((mrs_go && (cmd_in.ba == MR_SEL_STD))
         |=> (ls_r.mode_reg == $past(cmd_in.addr)))
      else $error("mode register not loaded");
   AST_SR_DEAF: assert property (((ls_r.pw == PW_SELF_REF) && !cke_in)
         |=> (ls_r.pw == PW_SELF_REF) && $stable(ls_r.bank_st) && !dq_oe_out)
      else $error("self refresh reacted to pins");

   COV_READ: cover property (rd_go ##2 dq_oe_out);
   COV_WRITE: cover property (wr_go ##1 (!any_go) [*2]);
   COV_TERMINATE: cover property (bst_go);
   COV_SELF_REF: cover property (sr_go ##1 (ls_r.pw == PW_SELF_REF));
   COV_DEEP_PD: cover property (dpd_go);

endmodule
